// ===== hdl/scm_decode.v
// How it works
// - Type field selects translate, bypass or fault
// - Reserved type code behaves as fault
// - Memory attribute code used only when selected
// - Bit 11 picks default or programmed attributes
// - Extended valid bit ignored unless globally enabled
// - Extended valid bit reserved without support flag
// - Shareability override decoded four ways
// - Unimplemented override fields read zero
// - Index width common, unused bits read zero
// - Bypass forwards untranslated with attribute overrides
// - Transient hint decoded in bypass
// - Force broadcast upgrades maintenance operations
// - Barrier upgrade raises minimum barrier domain
// - Barrier field reads zero if absent
// - Write allocate hint decoded
// - Read allocate hint decoded
// - Security override only in secure groups
// - Bypass tag zero if absent, secure tag ignored unless supported
// - Bypass tag narrowed to the index width on write
// - Fault format raises invalid context fault
// - Unimplemented mapping registers read zero
// - Mapping registers are 32-bit read write
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "scm_regs.vh"
module scm_decode (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire extended_id_support_flag,
  input wire secure_vm_tag_support,
  input wire match_valid,
  input wire [2:0] match_group,
  input wire maint_op,
  input wire barrier_op,
  input wire [1:0] in_barrier_domain,
  output reg out_valid,
  output reg out_translate,
  output reg out_bypass,
  output reg out_fault,
  output reg out_group_valid,
  output reg [7:0] out_context_bank_index,
  output reg [7:0] out_virtual_machine_tag,
  output reg out_mem_override,
  output reg [3:0] out_memory_attribute_code,
  output reg [1:0] out_shareability,
  output reg [1:0] out_transient,
  output reg [1:0] out_write_alloc,
  output reg [1:0] out_read_alloc,
  output reg [1:0] out_security,
  output reg out_broadcast,
  output reg [1:0] out_barrier_domain
);
  // Mapping storage; reset to fault so an unprogrammed group never translates
  reg [31:0] map_word [0:`SCM_NUM_GROUPS-1];
  reg extended_id_global_enable;
  reg [7:0] fault_count;
  reg [31:0] next_prdata;
  reg [31:0] sel_word;
  reg [1:0] sel_type;
  reg is_fault;
  reg is_bypass;
  reg is_secure_grp;
  reg [1:0] raised_dom;
  wire setup = psel & ~penable;
  wire in_map = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
  wire map_hit = in_map && (paddr[7:2] < `SCM_NUM_GROUPS);
  wire [2:0] map_idx = paddr[4:2];
  integer i;

  // Read mux; out-of-range slots give zero so reads of absent groups are harmless
  always @* begin
    next_prdata = 32'h00000000;
    if (map_hit) begin
      next_prdata = map_word[map_idx];
    end else if (paddr == `SCM_CFG_ADDR) begin
      next_prdata = {31'h00000000, extended_id_global_enable};
    end else if (paddr == `SCM_STAT_ADDR) begin
      next_prdata = {24'h000000, fault_count};
    end
  end

  // APB slave: one wait-free access phase; writes land at the access edge
  always @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      extended_id_global_enable <= 1'b0;
      for (i = 0; i < `SCM_NUM_GROUPS; i = i + 1) begin
        map_word[i] <= 32'h00020000;
      end
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : next_prdata;
      end
      if (psel & penable & pready & pwrite) begin
        if (map_hit) begin
          // Absent fields and unused index bits are dropped on write
          map_word[map_idx] <= pwdata & `SCM_IMPL_MASK;
        end else if (paddr == `SCM_CFG_ADDR) begin
          extended_id_global_enable <= pwdata[`SCM_CFG_EXID_EN];
        end
      end
    end
  end

  // Combinational decode of the matched group, same cycle as the match
  always @* begin
    sel_word = map_word[match_group];
    sel_type = sel_word[`SCM_TYPE_HI:`SCM_TYPE_LO];
    is_secure_grp = (match_group >= `SCM_SECURE_FIRST);
    // Reserved code folds into fault so no transaction escapes unchecked
    is_fault = (sel_type == `SCM_TYPE_FAULT) || (sel_type == `SCM_TYPE_RSVD);
    is_bypass = (sel_type == `SCM_TYPE_BYPASS);
    // Barrier floor: in bypass, take the wider of incoming and programmed domain; otherwise the incoming domain
    raised_dom = in_barrier_domain;
    if (is_bypass && sel_word[`SCM_BSU_HI:`SCM_BSU_LO] > in_barrier_domain) begin
      raised_dom = sel_word[`SCM_BSU_HI:`SCM_BSU_LO];
    end
  end

  // Registered outputs; the decode is combinational, the flop only isolates pins
  always @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_translate <= 1'b0;
      out_bypass <= 1'b0;
      out_fault <= 1'b0;
      out_group_valid <= 1'b0;
      out_context_bank_index <= 8'h00;
      out_virtual_machine_tag <= 8'h00;
      out_mem_override <= 1'b0;
      out_memory_attribute_code <= 4'h0;
      out_shareability <= 2'h0;
      out_transient <= 2'h0;
      out_write_alloc <= 2'h0;
      out_read_alloc <= 2'h0;
      out_security <= 2'h0;
      out_broadcast <= 1'b0;
      out_barrier_domain <= 2'h0;
      fault_count <= 8'h00;
    end else begin
      out_valid <= match_valid;
      out_translate <= match_valid && (sel_type == `SCM_TYPE_XLATE);
      out_bypass <= match_valid && is_bypass;
      out_fault <= match_valid && is_fault;
      if (match_valid && is_fault && fault_count != 8'hFF) begin
        fault_count <= fault_count + 8'h01;
      end
      // Without support the bit is reserved; without enable it is ignored
      if (extended_id_support_flag && extended_id_global_enable) begin
        out_group_valid <= sel_word[`SCM_EXID_BIT];
      end else begin
        out_group_valid <= 1'b1;
      end
      // Index only meaningful in translation format
      out_context_bank_index <= (sel_type == `SCM_TYPE_XLATE) ?
        (sel_word[`SCM_IDX_HI:`SCM_IDX_LO] & `SCM_IDX_MASK) : 8'h00;
      // Tag from the index field, only 3 bits after the write mask; secure tag dropped when unsupported
      out_virtual_machine_tag <= (is_bypass && (!is_secure_grp || secure_vm_tag_support)) ?
        sel_word[`SCM_IDX_HI:`SCM_IDX_LO] : 8'h00;
      // Attribute code passes only when bit 11 selects it
      out_mem_override <= !is_fault && sel_word[`SCM_MEMORY_TYPE_OVERRIDE_SELECT_BIT];
      out_memory_attribute_code <= (!is_fault && sel_word[`SCM_MEMORY_TYPE_OVERRIDE_SELECT_BIT]) ?
        sel_word[`SCM_MEMORY_ATTRIBUTE_CODE_HI:`SCM_MEMORY_ATTRIBUTE_CODE_LO] : 4'h0;
      // 0 default, 1 outer, 2 inner, 3 non-shareable
      out_shareability <= is_fault ? 2'h0 : sel_word[`SCM_SH_HI:`SCM_SH_LO];
      // Bypass-only hints; reserved code 1 is treated as default
      out_transient <= (is_bypass && sel_word[`SCM_TRANS_HI]) ? sel_word[`SCM_TRANS_HI:`SCM_TRANS_LO] : 2'h0;
      out_write_alloc <= (is_bypass && sel_word[`SCM_WA_HI]) ? sel_word[`SCM_WA_HI:`SCM_WA_LO] : 2'h0;
      out_read_alloc <= (is_bypass && sel_word[`SCM_RA_HI]) ? sel_word[`SCM_RA_HI:`SCM_RA_LO] : 2'h0;
      // Non-secure groups treat the field as reserved
      out_security <= (is_bypass && is_secure_grp && sel_word[`SCM_NS_HI]) ?
        sel_word[`SCM_NS_HI:`SCM_NS_LO] : 2'h0;
      out_broadcast <= maint_op && is_bypass && sel_word[`SCM_FB_BIT];
      out_barrier_domain <= barrier_op ? raised_dom : 2'h0;
    end
  end
endmodule // scm_decode

// ===== hdl/scm_regs.vh
`ifndef SCM_REGS_VH
`define SCM_REGS_VH
// Register map: one word per mapping group, group n at byte 4*n
`define SCM_MAP_BASE 12'h000
`define SCM_NUM_GROUPS 8
`define SCM_GROUP_BITS 3
`define SCM_CFG_ADDR 12'h100
`define SCM_STAT_ADDR 12'h104
// Field positions of the mapping word
`define SCM_TYPE_HI 17
`define SCM_TYPE_LO 16
`define SCM_MEMORY_ATTRIBUTE_CODE_HI 15
`define SCM_MEMORY_ATTRIBUTE_CODE_LO 12
`define SCM_MEMORY_TYPE_OVERRIDE_SELECT_BIT 11
`define SCM_EXID_BIT 10
`define SCM_SH_HI 9
`define SCM_SH_LO 8
`define SCM_IDX_HI 7
`define SCM_IDX_LO 0
`define SCM_TRANS_HI 29
`define SCM_TRANS_LO 28
`define SCM_FB_BIT 26
`define SCM_BSU_HI 25
`define SCM_BSU_LO 24
`define SCM_WA_HI 23
`define SCM_WA_LO 22
`define SCM_RA_HI 21
`define SCM_RA_LO 20
`define SCM_NS_HI 19
`define SCM_NS_LO 18
// Type codes
`define SCM_TYPE_XLATE 2'h0
`define SCM_TYPE_BYPASS 2'h1
`define SCM_TYPE_FAULT 2'h2
`define SCM_TYPE_RSVD 2'h3
// Implemented field mask: index width, optional fields present
`define SCM_IDX_MASK 8'h07
`define SCM_IMPL_MASK 32'h37FFFF07
// Config register bits
`define SCM_CFG_EXID_EN 0
// Secure groups are the top ones, from this index upward
`define SCM_SECURE_FIRST 3'h6
`endif

// ===== test/scm_client.sv
`timescale 1ns/1ns
module scm_client (
  input wire logic clock,
  output logic match_valid,
  output logic [2:0] match_group,
  output logic maint_op,
  output logic barrier_op,
  output logic [1:0] in_barrier_domain
);
  initial begin
    match_valid = 1'b0;
    match_group = 3'h0;
    maint_op = 1'b0;
    barrier_op = 1'b0;
    in_barrier_domain = 2'h0;
  end
  // One-cycle request; qualifiers then inverted so a stale sample shows
  task issue(input logic [2:0] g, input logic m, input logic b, input logic [1:0] d);
    @(posedge clock);
    match_valid <= 1'b1;
    match_group <= g;
    maint_op <= m;
    barrier_op <= b;
    in_barrier_domain <= d;
    @(posedge clock);
    match_valid <= 1'b0;
    match_group <= ~g;
    maint_op <= ~m;
    barrier_op <= ~b;
    in_barrier_domain <= ~d;
  endtask
endmodule // scm_client

// ===== test/scm_decode_properties.sv
`timescale 1ns/1ns
module scm_decode_properties (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire match_valid,
  input wire maint_op,
  input wire out_valid,
  input wire out_translate,
  input wire out_bypass,
  input wire out_fault,
  input wire [7:0] out_context_bank_index,
  input wire out_mem_override,
  input wire [3:0] out_memory_attribute_code,
  input wire out_broadcast
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Zero-wait slave, so the answer must be in the access cycle
  chk_apb_answer: assert property (psel && !penable |=> pready) else $error("late answer");
  chk_no_error: assert property (!pslverr) else $error("error flagged");
  chk_decode_latency: assert property (1 |=> out_valid == $past(match_valid)) else $error("decode late");
  chk_one_kind: assert property (out_valid |-> $onehot({out_translate, out_bypass, out_fault})) else $error("kind");
  chk_index_gated: assert property (out_valid && !out_translate |-> out_context_bank_index == 8'h00) else $error("idx");
  chk_index_width: assert property (out_context_bank_index[7:3] == 5'h00) else $error("idx width");
  chk_mem_gated: assert property (!out_mem_override |-> out_memory_attribute_code == 4'h0) else $error("mem");
  chk_bcast_cause: assert property (out_broadcast |-> out_bypass && $past(maint_op)) else $error("bcast");
  // Main scenarios reached
  cover property (match_valid ##1 out_translate);
  cover property (match_valid ##1 out_bypass);
  cover property (match_valid ##1 out_fault);
endmodule // scm_decode_properties
bind scm_decode scm_decode_properties scm_decode_properties_inst (.*);

// ===== test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, match_valid, maint_op, barrier_op, out_valid;
  logic out_translate, out_bypass, out_fault, out_group_valid, out_mem_override, out_broadcast, byp, flt;
  logic extended_id_support_flag, secure_vm_tag_support;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, w;
  logic [2:0] match_group;
  logic [1:0] in_barrier_domain, out_shareability, out_transient, out_write_alloc, out_read_alloc;
  logic [1:0] out_security, out_barrier_domain;
  logic [7:0] out_context_bank_index, out_virtual_machine_tag;
  logic [3:0] out_memory_attribute_code;
  int mismatches, comparisons;
  scm_decode scm_decode_inst (.*);
  scm_client scm_client_inst (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task test_done;
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {extended_id_support_flag, secure_vm_tag_support} = 2'h3;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    apb(0, 12'h000, 0); chk(q, 32'h00020000, "reset word");
    apb(1, 12'h004, '1); apb(0, 12'h004, 0); chk(q, 32'h37FFFF07, "mask");
    apb(1, 12'h020, '1); apb(0, 12'h020, 0); chk(q, 32'h0, "unmapped");
    for (int t = 0; t < 4; t++) begin
      w = {4'h3, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'(t), 4'hA, 2'h3, 2'h1, 8'h05};
      apb(1, 12'h008, w);
      scm_client_inst.issue(3'h2, 1'b1, 1'b1, 2'h1);
      #1;
      byp = (t == 1);
      flt = (t > 1);
      chk({out_translate, out_bypass, out_fault}, {t == 0, byp, flt}, "kind");
      chk(out_context_bank_index, t == 0 ? 8'h05 : 8'h00, "index");
      chk({out_mem_override, out_memory_attribute_code}, flt ? 5'h00 : 5'h1A, "mem attr");
      chk({out_broadcast, out_barrier_domain, out_transient, out_write_alloc, out_read_alloc},
          byp ? 9'h1BB : 9'h040, "bypass hints");
      chk({out_virtual_machine_tag, out_security}, byp ? 10'h014 : 10'h0, "tag");
      if (!flt) chk(out_shareability, 2'h1, "share");
    end
    apb(0, 12'h104, 0); chk(q, 32'h00000002, "fault count");
    apb(1, 12'h018, 32'h000DF000);
    scm_client_inst.issue(3'h6, 1'b0, 1'b0, 2'h0);
    #1 chk({out_security, out_mem_override, out_memory_attribute_code}, 7'h60, "secure");
    apb(1, 12'h00C, 32'h0);
    apb(1, 12'h100, 32'h1);
    scm_client_inst.issue(3'h3, 1'b0, 1'b0, 2'h0);
    #1 chk(out_group_valid, 1'b0, "ext valid");
    @(posedge clock);
    extended_id_support_flag <= 1'b0;
    scm_client_inst.issue(3'h3, 1'b0, 1'b0, 2'h0);
    #1 chk(out_group_valid, 1'b1, "ext reserved");
    test_done();
  end
  // Tests take under a hundred cycles; cut a hang well beyond that
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    test_done();
  end
endmodule // tb_top
